// File: hw/core_branch_pkg.sv
// Constants and types shared by the branch and bit-operation core
package core_branch_pkg;

  // Data space layout
  localparam int         RAM_BYTES      = 256;
  localparam logic [7:0] SFR_SPACE      = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE  = 8'h20;

  // Core register addresses, valid on every register page
  localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW   = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH  = 8'h83;
  localparam logic [7:0] ADDR_STATUS    = 8'hD0;
  localparam logic [7:0] ADDR_PRI_ACC   = 8'hE0;
  localparam logic [7:0] ADDR_SEC_ACC   = 8'hF0;

  // Reset values and status word fields
  localparam logic [7:0] RST_STACK_PTR  = 8'h07;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [15:0] RST_PC        = 16'h0000;
  localparam int         CARRY_POS      = 7;
  localparam int         BANK_HI        = 4;
  localparam int         BANK_LO        = 3;

  // Opcodes handled here
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_SPARE_NOP = 8'hA5;
  localparam logic [7:0] OP_ANL_C     = 8'h82;
  localparam logic [7:0] OP_ANL_CN    = 8'hB0;
  localparam logic [7:0] OP_ORL_C     = 8'h72;
  localparam logic [7:0] OP_ORL_CN    = 8'hA0;
  localparam logic [7:0] OP_MOV_CB    = 8'hA2;
  localparam logic [7:0] OP_MOV_BC    = 8'h92;
  localparam logic [7:0] OP_JBC       = 8'h10;
  localparam logic [7:0] OP_JB        = 8'h20;
  localparam logic [7:0] OP_JNB       = 8'h30;
  localparam logic [7:0] OP_JC        = 8'h40;
  localparam logic [7:0] OP_JNC       = 8'h50;
  localparam logic [7:0] OP_JZ        = 8'h60;
  localparam logic [7:0] OP_JNZ       = 8'h70;
  localparam logic [7:0] OP_LONG_JUMP      = 8'h02;
  localparam logic [7:0] OP_LONG_CALL     = 8'h12;
  localparam logic [7:0] OP_RET       = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_RETURN      = 8'h32;
  localparam logic [7:0] OP_JIND      = 8'h73;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP      = 8'h80;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_IMM  = 8'hB4;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_DIR  = 8'hB5;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_DIR  = 8'hD5;
  localparam logic [7:0] OP_PCALL_PAT = 8'b???1_0001;
  localparam logic [7:0] OP_PJMP_PAT  = 8'b???0_0001;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_IND  = 8'b1011_011?;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_REG  = 8'b1011_1???;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_REG  = 8'b1101_1???;

  // Instruction lengths in bytes and base cycle counts
  localparam logic [1:0] LEN1 = 2'd1;
  localparam logic [1:0] LEN2 = 2'd2;
  localparam logic [1:0] LEN3 = 2'd3;
  localparam logic [2:0] CYC1 = 3'd1;
  localparam logic [2:0] CYC2 = 3'd2;
  localparam logic [2:0] CYC3 = 3'd3;
  localparam logic [2:0] CYC4 = 3'd4;
  localparam logic [2:0] CYC5 = 3'd5;

  typedef enum logic [3:0] {
    K_NOP, K_BITC, K_JCY, K_JBIT, K_PCALL, K_LONG_CALL, K_RET, K_PJMP,
    K_LONG_JUMP, K_SHORT_RELATIVE_JUMP, K_JIND, K_JACC, K_COMPARE_JUMP_UNEQUAL, K_DECREMENT_JUMP_NONZERO, K_OTHER
  } op_kind_t;

  typedef struct packed {
    op_kind_t   kind;
    logic [1:0] len;
    logic [2:0] cycles;
    logic       cond;    // One more cycle when taken
  } op_info_t;

  typedef struct packed {
    logic       en;
    logic       sfr;
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_t;

endpackage

// File: hw/op_classify.sv
// Opcode classifier: kind, length and cycle count of each instruction
`timescale 1ns/10ps
module op_classify
  import core_branch_pkg::*;
(
  // Opcode in, class out
  input  wire logic [7:0] op_in,
  output op_info_t        info_out
);

  function automatic op_info_t mk(input op_kind_t k, input logic [1:0] l,
                                  input logic [2:0] c, input logic t);
    return '{kind: k, len: l, cycles: c, cond: t};
  endfunction

  // =====================================================================
  // Decode table
  always_comb begin
    unique casez (op_in)
      OP_NOP, OP_SPARE_NOP:           info_out = mk(K_NOP, LEN1, CYC1, 1'b0);
      OP_ANL_C, OP_ANL_CN, OP_ORL_C,
      OP_ORL_CN, OP_MOV_CB, OP_MOV_BC: info_out = mk(K_BITC, LEN2, CYC2, 1'b0);
      OP_JC, OP_JNC:                  info_out = mk(K_JCY, LEN2, CYC2, 1'b1);
      OP_JB, OP_JNB, OP_JBC:          info_out = mk(K_JBIT, LEN3, CYC3, 1'b1);
      OP_PCALL_PAT:                   info_out = mk(K_PCALL, LEN2, CYC3, 1'b0);
      OP_LONG_CALL:                       info_out = mk(K_LONG_CALL, LEN3, CYC4, 1'b0);
      OP_RET, OP_INTERRUPT_RETURN:                info_out = mk(K_RET, LEN1, CYC5, 1'b0);
      OP_PJMP_PAT:                    info_out = mk(K_PJMP, LEN2, CYC3, 1'b0);
      OP_LONG_JUMP:                        info_out = mk(K_LONG_JUMP, LEN3, CYC4, 1'b0);
      OP_SHORT_RELATIVE_JUMP:                        info_out = mk(K_SHORT_RELATIVE_JUMP, LEN2, CYC3, 1'b0);
      OP_JIND:                        info_out = mk(K_JIND, LEN1, CYC3, 1'b0);
      OP_JZ, OP_JNZ:                  info_out = mk(K_JACC, LEN2, CYC2, 1'b1);
      OP_COMPARE_JUMP_UNEQUAL_IMM, OP_COMPARE_JUMP_UNEQUAL_DIR,
      OP_COMPARE_JUMP_UNEQUAL_IND, OP_COMPARE_JUMP_UNEQUAL_REG:       info_out = mk(K_COMPARE_JUMP_UNEQUAL, LEN3, CYC3, 1'b1);
      OP_DECREMENT_JUMP_NONZERO_REG:                    info_out = mk(K_DECREMENT_JUMP_NONZERO, LEN2, CYC2, 1'b1);
      OP_DECREMENT_JUMP_NONZERO_DIR:                    info_out = mk(K_DECREMENT_JUMP_NONZERO, LEN3, CYC3, 1'b1);
      // Everything else belongs to other execution units
      default:                        info_out = mk(K_OTHER, LEN1, CYC1, 1'b0);
    endcase
  end

endmodule

// File: hw/branch_bitop_core.sv
// Branch, call, bit-to-carry sequencer with core registers and data RAM
//
// Operation
// - Carry jumps: two bytes, two cycles, three when taken.
// - Direct-bit jumps: three bytes, 3/4 cycles; set-then-clear form clears bit.
// - Bit/carry AND-not, OR, OR-not, copy in, copy out: two bytes, two cycles.
// - Page call two bytes three cycles; long call three bytes four cycles.
// - Return and interrupt return: one byte, five cycles.
// - Page jump 3, long jump 4, short jump 3, indirect jump 3 cycles.
// - Accumulator zero/nonzero jumps: two bytes, 2/3 cycles.
// - Compare-jump-unequal forms: three bytes, 3/4 cycles.
// - Decrement-jump: register 2 bytes 2/3, direct 3 bytes 3/4; decrement first.
// - No-op and spare opcode 0xA5: one byte, one cycle.
// - Register operands pick R0..R7 in the selected bank.
// - Indirect operands use R0 or R1 contents as RAM address.
// - Relative targets: next instruction address plus signed 8-bit offset.
// - Direct addresses below 0x80 hit RAM, the rest hit registers.
// - Page targets keep upper bits of the next instruction address.
// - Long targets may be anywhere in 64 kB program memory.
// - Pointer bytes at 0x82/0x83 form a 16-bit pointer, reset zero.
// - Stack pointer at 0x81 increments before each push, resets 0x07.
// - Primary accumulator at 0xE0, bit addressable, resets zero.
// - Secondary accumulator at 0xF0, bit addressable, resets zero.
// - Core registers answer on every register page.
// - Two-bit bank field picks register bank at 0x00/0x08/0x10/0x18.
// - Carry set by carry or borrow, cleared by other arithmetic.
`timescale 1ns/10ps
module branch_bitop_core
  import core_branch_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Program memory
  input  wire logic [7:0]  code_data_in,
  output logic      [15:0] code_addr_out,
  // Data port for the rest of the core
  input  wire logic        sys_wr_en_in,
  input  wire logic        sys_sfr_in,
  input  wire logic [7:0]  sys_addr_in,
  input  wire logic [7:0]  sys_wdata_in,
  output logic      [7:0]  sys_rdata_out,
  // Visible core state
  output logic             carry_flag_out,
  output logic      [1:0]  bank_select_field_out,
  output logic      [15:0] data_pointer_out,
  output logic      [7:0]  stack_top_pointer_out,
  output logic      [7:0]  primary_accumulator_out,
  output logic             instr_done_out,
  output logic             foreign_opcode_out
);

  // =====================================================================
  // State
  logic [7:0]  ram_q [RAM_BYTES];
  logic [7:0]  stack_top_pointer_q, pointer_low_byte_q, pointer_high_byte_q;
  logic [7:0]  primary_accumulator_q, secondary_accumulator_q, status_q;
  logic [15:0] pc_q, ret_q;
  logic [2:0]  cyc_q;
  logic [7:0]  op_q, b1_q;
  logic        taken_q;

  // Combinational sequencing
  op_info_t    info;
  logic [7:0]  op_now;
  logic [15:0] pc_inc, pc_d;
  logic [2:0]  exec_cyc, last_cyc;
  logic        exec, second, taken_c, taken_now, done;
  logic        cy_set, cy_val, sp_mv;
  logic [7:0]  sp_d, status_d, lhs, rhs, dec_v, rb;
  logic [1:0]  bank;
  wr_req_t     wr;

  // =====================================================================
  // Helpers
  function automatic logic [7:0] bank_reg(input logic [1:0] bk, input logic [2:0] idx);
    return {3'b000, bk, idx};
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] v;
    v = RST_ZERO;
    // No page term in the decode: core registers are always visible
    unique case (a)
      ADDR_STACK_PTR: v = stack_top_pointer_q;
      ADDR_PTR_LOW:   v = pointer_low_byte_q;
      ADDR_PTR_HIGH:  v = pointer_high_byte_q;
      ADDR_STATUS:    v = status_q;
      ADDR_PRI_ACC:   v = primary_accumulator_q;
      ADDR_SEC_ACC:   v = secondary_accumulator_q;
      default:        v = RST_ZERO;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] read_space(input logic s, input logic [7:0] a);
    return s ? sfr_read(a) : ram_q[a];
  endfunction

  function automatic logic [7:0] read_direct(input logic [7:0] a);
    return read_space(a >= SFR_SPACE, a);
  endfunction

  // Bit address to the byte that holds it
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    if (ba < SFR_SPACE) begin
      return BIT_AREA_BASE + {4'h0, ba[6:3]};
    end
    return {ba[7:3], 3'b000};
  endfunction

  function automatic logic bit_rd(input logic [7:0] ba);
    logic [7:0] v;
    v = read_direct(bit_byte(ba));
    return v[ba[2:0]];
  endfunction

  function automatic wr_req_t bit_wr(input logic [7:0] ba, input logic val);
    logic [7:0] v;
    v = read_direct(bit_byte(ba));
    v[ba[2:0]] = val;
    return '{en: 1'b1, sfr: ba >= SFR_SPACE, addr: bit_byte(ba), data: v};
  endfunction

  function automatic wr_req_t wr_ram(input logic [7:0] a, input logic [7:0] d);
    return '{en: 1'b1, sfr: 1'b0, addr: a, data: d};
  endfunction

  function automatic logic [15:0] rel(input logic [15:0] nxt, input logic [7:0] off);
    return nxt + {{8{off[7]}}, off};
  endfunction

  // Register update: internal write wins over the side port
  function automatic logic [7:0] sfr_next(input logic [7:0] cur, input logic [7:0] a);
    logic [7:0] v;
    v = cur;
    if (sys_wr_en_in && sys_sfr_in && sys_addr_in == a) begin
      v = sys_wdata_in;
    end
    if (wr.en && wr.sfr && wr.addr == a) begin
      v = wr.data;
    end
    return v;
  endfunction

  // =====================================================================
  // Decode
  assign op_now = (cyc_q == 3'd0) ? code_data_in : op_q;
  assign bank   = status_q[BANK_HI:BANK_LO];
  assign pc_inc = pc_q + 16'd1;
  assign rb     = bank_reg(bank, op_now[2:0]);

  op_classify u_classify (
    .op_in    (op_now),
    .info_out (info)
  );

  // =====================================================================
  // Execute: operand byte is still on code_data_in in the exec cycle
  always_comb begin
    exec_cyc = {1'b0, info.len} - 3'd1;
    exec     = cyc_q == exec_cyc;
    second   = cyc_q == {1'b0, info.len};
    pc_d     = (cyc_q <= exec_cyc) ? pc_inc : pc_q;
    taken_c  = 1'b0;
    cy_set   = 1'b0;
    cy_val   = status_q[CARRY_POS];
    sp_mv    = 1'b0;
    sp_d     = stack_top_pointer_q;
    wr       = '0;
    lhs      = primary_accumulator_q;
    rhs      = b1_q;
    dec_v    = RST_ZERO;
    if (exec) begin
      unique case (info.kind)
        K_BITC: begin
          cy_set = op_now != OP_MOV_BC;
          unique case (op_now)
            OP_ANL_C:  cy_val = status_q[CARRY_POS] & bit_rd(code_data_in);
            OP_ANL_CN: cy_val = status_q[CARRY_POS] & ~bit_rd(code_data_in);
            OP_ORL_C:  cy_val = status_q[CARRY_POS] | bit_rd(code_data_in);
            OP_ORL_CN: cy_val = status_q[CARRY_POS] | ~bit_rd(code_data_in);
            OP_MOV_CB: cy_val = bit_rd(code_data_in);
            default:   wr = bit_wr(code_data_in, status_q[CARRY_POS]);
          endcase
        end
        K_JCY: begin
          taken_c = (op_now == OP_JC) ? status_q[CARRY_POS] : ~status_q[CARRY_POS];
        end
        K_JBIT: begin
          taken_c = (op_now == OP_JNB) ? ~bit_rd(b1_q) : bit_rd(b1_q);
          if (op_now == OP_JBC && taken_c) begin
            wr = bit_wr(b1_q, 1'b0);
          end
        end
        K_PCALL, K_PJMP: begin
          taken_c = 1'b1;
          pc_d    = {pc_inc[15:11], op_now[7:5], code_data_in};
        end
        K_LONG_CALL, K_LONG_JUMP: begin
          taken_c = 1'b1;
          pc_d    = {b1_q, code_data_in};
        end
        K_RET: begin
          sp_mv = 1'b1;
          sp_d  = stack_top_pointer_q - 8'd1;
        end
        K_SHORT_RELATIVE_JUMP: taken_c = 1'b1;
        K_JIND: begin
          pc_d = {pointer_high_byte_q, pointer_low_byte_q}
                 + {8'h00, primary_accumulator_q};
        end
        K_JACC: begin
          taken_c = (primary_accumulator_q == RST_ZERO) ^ (op_now == OP_JNZ);
        end
        K_COMPARE_JUMP_UNEQUAL: begin
          if (op_now == OP_COMPARE_JUMP_UNEQUAL_DIR) begin
            rhs = read_direct(b1_q);
          end else if (op_now[3]) begin
            lhs = ram_q[rb];
          end else if (op_now != OP_COMPARE_JUMP_UNEQUAL_IMM) begin
            lhs = ram_q[ram_q[bank_reg(bank, {2'b00, op_now[0]})]];
          end
          taken_c = lhs != rhs;
          cy_set  = 1'b1;
          cy_val  = lhs < rhs;
        end
        K_DECREMENT_JUMP_NONZERO: begin
          if (op_now == OP_DECREMENT_JUMP_NONZERO_DIR) begin
            dec_v = read_direct(b1_q) - 8'd1;
            wr    = '{en: 1'b1, sfr: b1_q >= SFR_SPACE, addr: b1_q, data: dec_v};
          end else begin
            dec_v = ram_q[rb] - 8'd1;
            wr    = wr_ram(rb, dec_v);
          end
          taken_c = dec_v != RST_ZERO;
        end
        default: ;
      endcase
      // Relative forms take their offset from the final byte
      if (taken_c && info.kind inside {K_JCY, K_JBIT, K_SHORT_RELATIVE_JUMP, K_JACC, K_COMPARE_JUMP_UNEQUAL, K_DECREMENT_JUMP_NONZERO}) begin
        pc_d = rel(pc_inc, code_data_in);
      end
      // Calls push the low return byte now
      if (info.kind inside {K_PCALL, K_LONG_CALL}) begin
        sp_mv = 1'b1;
        sp_d  = stack_top_pointer_q + 8'd1;
        wr    = wr_ram(sp_d, pc_inc[7:0]);
      end
    end else if (second) begin
      if (info.kind inside {K_PCALL, K_LONG_CALL}) begin
        sp_mv = 1'b1;
        sp_d  = stack_top_pointer_q + 8'd1;
        wr    = wr_ram(sp_d, ret_q[15:8]);
      end else if (info.kind == K_RET) begin
        sp_mv = 1'b1;
        sp_d  = stack_top_pointer_q - 8'd1;
        pc_d  = {ret_q[15:8], ram_q[stack_top_pointer_q]};
      end
    end
    taken_now = exec ? taken_c : taken_q;
    last_cyc  = info.cycles - 3'd1 + {2'b00, info.cond & taken_now};
    done      = cyc_q == last_cyc;
  end

  // Status word: carry from bit ops overrides a byte write
  always_comb begin
    status_d = sfr_next(status_q, ADDR_STATUS);
    if (cy_set) begin
      status_d[CARRY_POS] = cy_val;
    end
  end

  // =====================================================================
  // Sequencer registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cyc_q   <= 3'd0;
      pc_q    <= RST_PC;
      op_q    <= RST_ZERO;
      b1_q    <= RST_ZERO;
      taken_q <= 1'b0;
    end else begin
      cyc_q <= done ? 3'd0 : cyc_q + 3'd1;
      pc_q  <= pc_d;
      if (cyc_q == 3'd0) begin
        op_q <= code_data_in;
      end
      if (cyc_q == 3'd1) begin
        b1_q <= code_data_in;
      end
      if (exec) begin
        taken_q <= taken_c;
      end
    end
  end

  // Return address: saved on call, high byte popped first on return
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ret_q <= RST_PC;
    end else if (exec && info.kind inside {K_PCALL, K_LONG_CALL}) begin
      ret_q <= pc_inc;
    end else if (exec && info.kind == K_RET) begin
      ret_q[15:8] <= ram_q[stack_top_pointer_q];
    end
  end

  // =====================================================================
  // Data RAM: no reset, contents are software data
  always_ff @(posedge clk_in) begin
    if (sys_wr_en_in && !sys_sfr_in) begin
      ram_q[sys_addr_in] <= sys_wdata_in;
    end
    if (wr.en && !wr.sfr) begin
      ram_q[wr.addr] <= wr.data;
    end
  end

  // Core registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stack_top_pointer_q     <= RST_STACK_PTR;
      pointer_low_byte_q      <= RST_ZERO;
      pointer_high_byte_q     <= RST_ZERO;
      primary_accumulator_q   <= RST_ZERO;
      secondary_accumulator_q <= RST_ZERO;
      status_q                <= RST_ZERO;
    end else begin
      stack_top_pointer_q     <= sp_mv ? sp_d : sfr_next(stack_top_pointer_q, ADDR_STACK_PTR);
      pointer_low_byte_q      <= sfr_next(pointer_low_byte_q, ADDR_PTR_LOW);
      pointer_high_byte_q     <= sfr_next(pointer_high_byte_q, ADDR_PTR_HIGH);
      primary_accumulator_q   <= sfr_next(primary_accumulator_q, ADDR_PRI_ACC);
      secondary_accumulator_q <= sfr_next(secondary_accumulator_q, ADDR_SEC_ACC);
      status_q                <= status_d;
    end
  end

  // =====================================================================
  // Outputs, all registered
  assign code_addr_out         = pc_q;
  assign carry_flag_out        = status_q[CARRY_POS];
  assign bank_select_field_out = status_q[BANK_HI:BANK_LO];
  assign data_pointer_out      = {pointer_high_byte_q, pointer_low_byte_q};
  assign stack_top_pointer_out = stack_top_pointer_q;
  assign primary_accumulator_out = primary_accumulator_q;

  // Read data lags the request by one edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sys_rdata_out      <= RST_ZERO;
      instr_done_out     <= 1'b0;
      foreign_opcode_out <= 1'b0;
    end else begin
      sys_rdata_out      <= read_space(sys_sfr_in, sys_addr_in);
      instr_done_out     <= done;
      foreign_opcode_out <= cyc_q == 3'd0 && info.kind == K_OTHER;
    end
  end

endmodule

// File: test/prog_mem_model.sv
// Program memory model answering fetches in the same cycle
`timescale 1ns/10ps
module prog_mem_model (
  // Fetch port
  input  wire logic [15:0] addr_in,
  output logic      [7:0]  data_out
);
  logic [7:0] rom [0:65535];

  // Blank bytes read as no-op so unloaded gaps simply fall through
  initial begin
    foreach (rom[i]) rom[i] = 8'h00;
  end

  // Combinational read; the core samples it at every edge
  assign data_out = rom[addr_in];
endmodule

// File: test/core_branch_sva.sv
// Port checker for the branch and bit-operation core
`timescale 1ns/10ps
module core_branch_sva
  import core_branch_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  code_data_in,
  input wire logic [15:0] code_addr_out,
  input wire logic        sys_wr_en_in,
  input wire logic        sys_sfr_in,
  input wire logic [7:0]  sys_addr_in,
  input wire logic [7:0]  sys_wdata_in,
  input wire logic [7:0]  sys_rdata_out,
  input wire logic        carry_flag_out,
  input wire logic [15:0] data_pointer_out,
  input wire logic [7:0]  stack_top_pointer_out,
  input wire logic [7:0]  primary_accumulator_out,
  input wire logic        instr_done_out
);
  // ==========================================
  // Helpers: done pulse marks opcode cycle
  logic [15:0] pc_nx;
  assign pc_nx = code_addr_out + 16'd1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================
  // Assertions
  a_reset_values: assert property (
    $rose(arst_n_in) |-> stack_top_pointer_out == RST_STACK_PTR
      && data_pointer_out == 16'h0000 && primary_accumulator_out == RST_ZERO
  ) else $error("core registers not at reset values");
  a_nop_one_cycle: assert property (
    instr_done_out && (code_data_in == OP_NOP || code_data_in == OP_SPARE_NOP)
      |=> instr_done_out && code_addr_out == $past(pc_nx)
  ) else $error("no-op not one byte one cycle");
  a_carry_fallthru: assert property (
    instr_done_out && code_data_in == OP_JC && !carry_flag_out
      |-> ##2 instr_done_out && code_addr_out == $past(code_addr_out, 2) + 16'd2
  ) else $error("untaken carry jump timing wrong");
  a_short_target: assert property (
    instr_done_out && code_data_in == OP_SHORT_RELATIVE_JUMP |-> ##3 instr_done_out && code_addr_out
      == $past(pc_nx, 2) + {{8{$past(code_data_in[7], 2)}}, $past(code_data_in, 2)}
  ) else $error("short jump target or timing wrong");
  a_long_target: assert property (
    instr_done_out && code_data_in == OP_LONG_JUMP |-> ##4 instr_done_out
      && code_addr_out == {$past(code_data_in, 3), $past(code_data_in, 2)}
  ) else $error("long jump target or timing wrong");
  a_page_target: assert property (
    instr_done_out && code_data_in[4:0] == 5'h01 |-> ##3 instr_done_out && code_addr_out
      == {$past(pc_nx[15:11], 2), $past(code_data_in[7:5], 3), $past(code_data_in, 2)}
  ) else $error("page jump target or timing wrong");
  a_long_call: assert property (
    instr_done_out && code_data_in == OP_LONG_CALL |-> ##4 instr_done_out
      && stack_top_pointer_out == $past(stack_top_pointer_out, 4) + 8'd2
  ) else $error("long call stack or timing wrong");
  a_return_five: assert property (
    instr_done_out && (code_data_in == OP_RET || code_data_in == OP_INTERRUPT_RETURN)
      |-> ##5 instr_done_out
      && stack_top_pointer_out == $past(stack_top_pointer_out, 5) - 8'd2
  ) else $error("return stack or timing wrong");
  a_acc_side_write: assert property (
    instr_done_out && code_data_in == OP_NOP && sys_wr_en_in && sys_sfr_in
      && sys_addr_in == ADDR_PRI_ACC |=> primary_accumulator_out == $past(sys_wdata_in)
  ) else $error("accumulator side write lost");
  a_read_latency: assert property (
    sys_sfr_in && sys_addr_in == ADDR_STACK_PTR
      |=> sys_rdata_out == $past(stack_top_pointer_out)
  ) else $error("stack pointer read wrong");

  // Main scenarios
  c_page_jump: cover property (instr_done_out && code_data_in[4:0] == 5'h01);
  c_long_call: cover property (instr_done_out && code_data_in == OP_LONG_CALL);
  c_carry_set: cover property ($rose(carry_flag_out));
endmodule

bind branch_bitop_core core_branch_sva chk_i (.*);

// File: test/tb.sv
// Testbench: side-port register tests and a branch program run
`timescale 1ns/10ps
module tb
  import core_branch_pkg::*;
();
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        sys_wr_en_in = 1'b0;
  logic        sys_sfr_in = 1'b0;
  logic [7:0]  sys_addr_in = 8'h00;
  logic [7:0]  sys_wdata_in = 8'h00;
  logic [7:0]  code_data_in, sys_rdata_out, stack_top_pointer_out, primary_accumulator_out;
  logic [15:0] code_addr_out, data_pointer_out;
  logic [1:0]  bank_select_field_out;
  logic        carry_flag_out, instr_done_out, foreign_opcode_out;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          foreign_seen = 0;
  // Program image {address, byte}; untaken OP_JZ, immediate compare-jump and OP_JBC paths land on self-loop traps
  localparam logic [23:0] PROG [40] = '{
    24'h0040A5, 24'h004140, 24'h004205, 24'h004360, 24'h004402, 24'h004580, 24'h0046FE,
    24'h004712, 24'h004801, 24'h004900, 24'h004A02, 24'h004B02, 24'h004C00, 24'h010022,
    24'h020021, 24'h020150, 24'h0150B4, 24'h015133, 24'h015203, 24'h015380, 24'h0154FE,
    24'h015692, 24'h015730, 24'h015810, 24'h015930, 24'h015A02, 24'h015B80, 24'h015CFE,
    24'h015DD8, 24'h015EFE, 24'h015F73, 24'h123451, 24'h123540, 24'h123680, 24'h1237FE,
    24'h1240B6, 24'h124107, 24'h1242FD, 24'h124332, 24'h0030E4};
  localparam logic [15:0] RST_TAB [6] = '{{ADDR_STACK_PTR, RST_STACK_PTR},
    {ADDR_PTR_LOW, RST_ZERO}, {ADDR_PTR_HIGH, RST_ZERO}, {ADDR_PRI_ACC, RST_ZERO},
    {ADDR_SEC_ACC, RST_ZERO}, {8'h85, 8'h00}};

  // ==========================================
  // Design and program memory
  branch_bitop_core dut (.*);
  prog_mem_model pm (.addr_in(code_addr_out), .data_out(code_data_in));

  initial forever #4 clk_in = ~clk_in;

  // ==========================================
  // Access tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single-cycle write strobe, launched off the falling edge
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sys_wr_en_in = 1'b1;
    sys_sfr_in = s;
    sys_addr_in = a;
    sys_wdata_in = d;
    @(negedge clk_in);
    sys_wr_en_in = 1'b0;
  endtask
  // Read data lands one edge after the address
  task automatic rd(input logic s, input logic [7:0] a, input string w, input logic [7:0] e);
    @(negedge clk_in);
    sys_sfr_in = s;
    sys_addr_in = a;
    @(negedge clk_in);
    check(w, {8'h00, e}, {8'h00, sys_rdata_out});
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 130 cycles needed
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Skipped opcodes: one foreign byte is placed, the spare no-op must not count
  always @(negedge clk_in) begin
    if (foreign_opcode_out === 1'b1) begin
      foreign_seen++;
    end
  end

  // ==========================================
  // Main sequence; side-port work fits in the leading no-op run
  initial begin
    #1;
    foreach (PROG[i]) pm.rom[PROG[i][23:8]] = PROG[i][7:0];
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    foreach (RST_TAB[i]) rd(1'b1, RST_TAB[i][15:8], "reset reg", RST_TAB[i][7:0]);
    wr(1'b1, ADDR_PRI_ACC, 8'h55);
    rd(1'b1, ADDR_PRI_ACC, "acc", 8'h55);
    wr(1'b1, ADDR_PRI_ACC, 8'h00);
    wr(1'b1, ADDR_SEC_ACC, 8'hA5);
    rd(1'b1, ADDR_SEC_ACC, "sec acc", 8'hA5);
    wr(1'b1, ADDR_PTR_LOW, 8'h34);
    wr(1'b1, ADDR_PTR_HIGH, 8'h12);
    check("data_pointer", 16'h1234, data_pointer_out);
    wr(1'b1, ADDR_STATUS, 8'h10);
    wr(1'b0, 8'h10, 8'h02);
    wr(1'b0, 8'h00, 8'h07);
    wr(1'b0, 8'h26, 8'h00);
    // Run to the final self-loop; traps stop a wrong branch short of it
    for (int i = 0; i < 600 && code_addr_out !== 16'h1236; i++) @(negedge clk_in);
    check("pc", 16'h1236, code_addr_out);
    check("sp", {8'h00, RST_STACK_PTR}, {8'h00, stack_top_pointer_out});
    check("carry", 16'h0000, {15'h0000, carry_flag_out});
    check("bank", 16'h0002, {14'h0000, bank_select_field_out});
    check("foreign", 16'h0001, foreign_seen[15:0]);
    rd(1'b0, 8'h08, "ret low", 8'h36);
    rd(1'b0, 8'h09, "ret high", 8'h12);
    rd(1'b0, 8'h10, "bank reg", 8'h00);
    rd(1'b0, 8'h00, "bank0 reg", 8'h07);
    rd(1'b0, 8'h26, "bit byte", 8'h00);
    tally_and_finish();
  end
endmodule
